/* File: rtl/uh_uart.sv */
// Half-buffered asynchronous serial port with APB registers
//
// What this block does
// [RQ1] Transmit flag set by request, cleared writing one
// [RQ2] Frame: start, 5-8 data, optional parity, stop
// [RQ3] One or two stops; LSB or MSB first
// [RQ4] Negative logic inverts output and input lines
// [RQ5] Generator counts selected clock, up to 16384
// [RQ6] Bit lasts programmed count plus one ticks
// [RQ7] Transmit starts on enable and data, any order
// [RQ8] Start, data, parity, stop on transfer-clock falls
// [RQ9] Transmit request raised when start bit begins
// [RQ10] Buffer write sets full; request after stop bit
// [RQ11] No pending data: halt, clear enable, request
// [RQ12] Host refills between request and stop end
// [RQ13] Receiver idles until a start edge appears
// [RQ14] Receive clock starts at detection, mid-bit samples
// [RQ15] Received data copied to buffer after last bit
// [RQ16] Next sample: request, check stop and parity
// [RQ17] Reception runs until software clears enable
// [RQ18] Start bit sampled on generator clock ticks
// [RQ19] Sample point shiftable one tick earlier
// [RQ20] Receive DMA request while a character waits
// [RQ21] Transmit DMA request while holding buffer empty
// [RQ22] Overrun when unread character is overwritten
// [RQ23] Sample point is half count, or minus one
// [RQ24] Full flag clears when data enters shifter
// [RQ25] Any error status write clears all errors
// [RQ26] Parity bit makes ones count even or odd
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module uh_uart
    import uh_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Generator clock sources, one-cycle ticks on sys_clk
    input  wire logic        lowSpeedTick,
    input  wire logic        highSpeedTick,
    // Serial line
    input  wire logic        rxdPin,
    output logic             txdPin,
    // Requests
    output logic             txIrqReq,
    output logic             rxIrqReq,
    output logic             txDmaReq,
    output logic             rxDmaReq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic               runEn;
        logic               txRunEn;
        logic [1:0]         clkSel;
        logic               rss;
        logic [1:0]         lenSel;
        logic [1:0]         parSel;
        logic               stop2;
        logic               neg;
        logic               msbFirst;
        logic [13:0]        brt;
        logic [31:0]        rdData;
        logic [7:0]         txHold;
        logic               txFull;
        logic [7:0]         txSh;
        uh_tx_state_t       txSt;
        logic [2:0]         txIdx;
        logic               txStopIdx;
        logic               txd;
        logic               rxMeta;
        logic               rxSync;
        uh_rx_state_t       rxSt;
        logic [2:0]         rxIdx;
        logic [7:0]         rxSh;
        logic               rxPar;
        logic               rxStartBad;
        logic [7:0]         rxBuf;
        logic               rxUnread;
        logic               ovrPend;
        logic               perFlag;
        logic               oerFlag;
        logic               ferFlag;
        logic               txIrqFlag;
        logic               rxIrqFlag;
        logic               txIrqPulse;
        logic               rxIrqPulse;
    } uh_state_t;

    uh_state_t s_r;
    uh_state_t s_nxt;

    logic        genTick;
    logic [13:0] txCnt;
    logic        txWrap;
    logic [13:0] rxCnt;
    logic        rxWrap;
    logic [13:0] halfCnt;
    logic [13:0] samplePt;
    logic        rxSample;
    logic        rxBit;
    logic [2:0]  lastIdx;
    logic [7:0]  dataMask;
    logic        parEn;
    logic        parOdd;
    logic        wrEn;
    logic        rdSetup;
    logic        mapped;
    logic [31:0] rdMux;

    // ------------------------------------------------------------
    // Frame decode and generator clock
    // ------------------------------------------------------------
    // Only the two documented sources run the generator; other codes stall it
    assign genTick  = (s_r.clkSel == UH_CK_HIGH) ? highSpeedTick :
                      (s_r.clkSel == UH_CK_LOW)  ? lowSpeedTick  : 1'b0;  // see [RQ5]
    assign lastIdx  = UH_LAST_BIT8 - {1'b0, s_r.lenSel};                  // see [RQ2]
    assign dataMask = UH_DATA_MASK8 >> s_r.lenSel;
    assign parEn    = !s_r.parSel[1];
    assign parOdd   = s_r.parSel[0];
    assign rxBit    = s_r.rxSync ^ s_r.neg;                                // see [RQ4]

    // Sample point; with a count of zero or one the shift would wrap, so clamp
    assign halfCnt  = s_r.brt >> 1;
    assign samplePt = (s_r.rss && halfCnt != '0) ? halfCnt - 1'b1 : halfCnt; // see [RQ19] [RQ23]
    assign rxSample = (s_r.rxSt != UH_RX_IDLE) && genTick && (rxCnt == samplePt); // see [RQ14]

    // Two bit timers: both sides run the same period, each from its own origin
    uh_bit_timer #(.W(UH_BRT_W)) u_tx_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (s_r.txSt != UH_TX_IDLE),
        .tick    (genTick),
        .top     (s_r.brt),                 // see [RQ6]
        .count   (txCnt),
        .wrap    (txWrap)
    );

    uh_bit_timer #(.W(UH_BRT_W)) u_rx_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (s_r.rxSt != UH_RX_IDLE),  // see [RQ14]
        .tick    (genTick),
        .top     (s_r.brt),
        .count   (rxCnt),
        .wrap    (rxWrap)
    );

    // ------------------------------------------------------------
    // APB decode and read data
    // ------------------------------------------------------------
    assign wrEn    = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;

    // Read view of every register; reserved bits read as zero
    always_comb begin
        mapped = 1'b1;
        rdMux  = '0;
        case (paddr)
            UH_OFF_CTRL: begin
                rdMux[UH_CTRL_RUN]   = s_r.runEn;
                rdMux[UH_CTRL_TXRUN] = s_r.txRunEn;
            end
            UH_OFF_RXBUF: rdMux[7:0] = s_r.rxBuf;
            UH_OFF_MODE: begin
                rdMux[UH_MODE_CK_LSB +: 2]  = s_r.clkSel;
                rdMux[UH_MODE_RSS]          = s_r.rss;
                rdMux[UH_MODE_LEN_LSB +: 2] = s_r.lenSel;
                rdMux[UH_MODE_PAR_LSB +: 2] = s_r.parSel;
                rdMux[UH_MODE_STP]          = s_r.stop2;
                rdMux[UH_MODE_NEG]          = s_r.neg;
                rdMux[UH_MODE_DIR]          = s_r.msbFirst;
            end
            UH_OFF_BRT:  rdMux[UH_BRT_W-1:0] = s_r.brt;
            UH_OFF_RXSTAT: begin
                rdMux[UH_STAT_FER] = s_r.ferFlag;
                rdMux[UH_STAT_OER] = s_r.oerFlag;
                rdMux[UH_STAT_PER] = s_r.perFlag;
            end
            UH_OFF_TXBUF:  rdMux[7:0] = s_r.txHold;
            UH_OFF_TXSTAT: rdMux[UH_TXSTAT_FULL] = s_r.txFull;
            UH_OFF_INTF: begin
                rdMux[UH_INT_RX] = s_r.rxIrqFlag;
                rdMux[UH_INT_TX] = s_r.txIrqFlag;
            end
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Software clears come first and hardware sets after, so a set wins
    always_comb begin
        s_nxt            = s_r;
        s_nxt.txIrqPulse = 1'b0;
        s_nxt.rxIrqPulse = 1'b0;
        s_nxt.rxMeta     = rxdPin;
        s_nxt.rxSync     = s_r.rxMeta;

        // Read data is captured in the setup cycle so the access phase needs no wait
        if (rdSetup) begin
            s_nxt.rdData = rdMux;
        end

        // Flag clears by software
        if (wrEn && paddr == UH_OFF_INTF) begin
            if (pwdata[UH_INT_TX]) begin
                s_nxt.txIrqFlag = 1'b0;                                    // see [RQ1]
            end
            if (pwdata[UH_INT_RX]) begin
                s_nxt.rxIrqFlag = 1'b0;
            end
        end
        if (wrEn && paddr == UH_OFF_RXSTAT) begin
            s_nxt.perFlag = 1'b0;                                          // see [RQ25]
            s_nxt.oerFlag = 1'b0;
            s_nxt.ferFlag = 1'b0;
        end
        if (wrEn && paddr == UH_OFF_TXSTAT) begin
            s_nxt.txFull = 1'b0;
        end
        if (psel && penable && !pwrite && paddr == UH_OFF_RXBUF) begin
            s_nxt.rxUnread = 1'b0;
        end

        // Transmit sequencer, one step per bit period end
        case (s_r.txSt)
            UH_TX_IDLE: begin
                // Enable and data may arrive in either order
                if (s_r.txRunEn && s_r.txFull) begin                       // see [RQ7]
                    s_nxt.txSh       = s_r.txHold;
                    s_nxt.txFull     = 1'b0;                               // see [RQ24]
                    s_nxt.txSt       = UH_TX_START;
                    s_nxt.txd        = 1'b0;                               // see [RQ8]
                    s_nxt.txIrqPulse = 1'b1;                               // see [RQ9]
                end
            end
            UH_TX_START: begin
                if (txWrap) begin
                    s_nxt.txSt  = UH_TX_DATA;
                    s_nxt.txIdx = '0;
                    s_nxt.txd   = s_r.msbFirst ? s_r.txSh[lastIdx] : s_r.txSh[0]; // see [RQ3]
                end
            end
            UH_TX_DATA: begin
                if (txWrap) begin
                    if (s_r.txIdx == lastIdx) begin
                        s_nxt.txStopIdx = 1'b0;
                        if (parEn) begin
                            s_nxt.txSt = UH_TX_PAR;
                            s_nxt.txd  = ^(s_r.txSh & dataMask) ^ parOdd;  // see [RQ26]
                        end else begin
                            s_nxt.txSt = UH_TX_STOP;
                            s_nxt.txd  = 1'b1;
                        end
                    end else begin
                        s_nxt.txIdx = s_r.txIdx + 1'b1;
                        s_nxt.txd   = s_r.msbFirst ? s_r.txSh[lastIdx - s_r.txIdx - 1'b1]
                                                   : s_r.txSh[s_r.txIdx + 1'b1];  // see [RQ2]
                    end
                end
            end
            UH_TX_PAR: begin
                if (txWrap) begin
                    s_nxt.txSt = UH_TX_STOP;
                    s_nxt.txd  = 1'b1;
                end
            end
            UH_TX_STOP: begin
                if (txWrap) begin
                    if (s_r.stop2 && !s_r.txStopIdx) begin
                        s_nxt.txStopIdx = 1'b1;                            // see [RQ3]
                    end else if (s_r.txRunEn && s_r.txFull) begin
                        // Refilled in time: next frame follows with no idle gap
                        s_nxt.txSh       = s_r.txHold;                     // see [RQ12]
                        s_nxt.txFull     = 1'b0;                           // see [RQ24]
                        s_nxt.txSt       = UH_TX_START;
                        s_nxt.txd        = 1'b0;
                        s_nxt.txIrqPulse = 1'b1;                           // see [RQ10]
                    end else begin
                        s_nxt.txSt       = UH_TX_IDLE;
                        s_nxt.txRunEn    = 1'b0;                           // see [RQ11]
                        s_nxt.txIrqPulse = 1'b1;
                    end
                end
            end
            default: s_nxt.txSt = UH_TX_IDLE;
        endcase

        // Receive sequencer
        case (s_r.rxSt)
            UH_RX_IDLE: begin
                // Line is looked at only on generator ticks
                if (s_r.runEn && genTick && !rxBit) begin                  // see [RQ13] [RQ18]
                    s_nxt.rxSt       = UH_RX_START;
                    s_nxt.rxSh       = '0;
                    s_nxt.rxStartBad = 1'b0;
                end
            end
            UH_RX_START: begin
                if (rxSample) begin
                    s_nxt.rxStartBad = rxBit;
                end
                if (rxWrap) begin
                    s_nxt.rxSt  = UH_RX_DATA;
                    s_nxt.rxIdx = '0;
                end
            end
            UH_RX_DATA: begin
                if (rxSample) begin
                    if (s_r.msbFirst) begin
                        s_nxt.rxSh[lastIdx - s_r.rxIdx] = rxBit;           // see [RQ3]
                    end else begin
                        s_nxt.rxSh[s_r.rxIdx] = rxBit;
                    end
                end
                if (rxWrap) begin
                    if (s_r.rxIdx != lastIdx) begin
                        s_nxt.rxIdx = s_r.rxIdx + 1'b1;
                    end else if (parEn) begin
                        s_nxt.rxSt = UH_RX_PAR;
                    end else begin
                        s_nxt.rxBuf    = s_nxt.rxSh;                       // see [RQ15]
                        s_nxt.ovrPend  = s_r.rxUnread;
                        s_nxt.rxUnread = 1'b1;
                        s_nxt.rxSt     = UH_RX_STOP;
                    end
                end
            end
            UH_RX_PAR: begin
                if (rxSample) begin
                    s_nxt.rxPar = rxBit;
                end
                if (rxWrap) begin
                    s_nxt.rxBuf    = s_r.rxSh;                             // see [RQ15]
                    s_nxt.ovrPend  = s_r.rxUnread;                         // see [RQ22]
                    s_nxt.rxUnread = 1'b1;                                 // see [RQ20]
                    s_nxt.rxSt     = UH_RX_STOP;
                end
            end
            UH_RX_STOP: begin
                // Back to idle at mid stop bit so the next start edge is not missed
                if (rxSample) begin
                    s_nxt.rxIrqPulse = 1'b1;                               // see [RQ16]
                    if (s_r.rxStartBad || !rxBit) begin
                        s_nxt.ferFlag = 1'b1;
                    end
                    if (parEn && (^(s_r.rxSh & dataMask) ^ parOdd ^ s_r.rxPar)) begin
                        s_nxt.perFlag = 1'b1;                              // see [RQ26]
                    end
                    if (s_r.ovrPend) begin
                        s_nxt.oerFlag = 1'b1;                              // see [RQ22]
                    end
                    s_nxt.rxSt = UH_RX_IDLE;
                end
            end
            default: s_nxt.rxSt = UH_RX_IDLE;
        endcase

        // Dropping the enable abandons a frame; the buffer keeps its last capture
        if (!s_r.runEn) begin
            s_nxt.rxSt = UH_RX_IDLE;                                       // see [RQ17]
        end

        // Interrupt source flags, set by the request pulses
        if (s_nxt.txIrqPulse) begin
            s_nxt.txIrqFlag = 1'b1;                                        // see [RQ1]
        end
        if (s_nxt.rxIrqPulse) begin
            s_nxt.rxIrqFlag = 1'b1;
        end

        // Register writes; a software enable beats the end-of-frame clear
        if (wrEn) begin
            case (paddr)
                UH_OFF_CTRL: begin
                    s_nxt.runEn   = pwdata[UH_CTRL_RUN];
                    s_nxt.txRunEn = pwdata[UH_CTRL_TXRUN];
                end
                UH_OFF_MODE: begin
                    s_nxt.clkSel   = pwdata[UH_MODE_CK_LSB +: 2];
                    s_nxt.rss      = pwdata[UH_MODE_RSS];
                    s_nxt.lenSel   = pwdata[UH_MODE_LEN_LSB +: 2];
                    s_nxt.parSel   = pwdata[UH_MODE_PAR_LSB +: 2];
                    s_nxt.stop2    = pwdata[UH_MODE_STP];
                    s_nxt.neg      = pwdata[UH_MODE_NEG];
                    s_nxt.msbFirst = pwdata[UH_MODE_DIR];
                end
                UH_OFF_BRT: s_nxt.brt = pwdata[UH_BRT_W-1:0];              // see [RQ5]
                UH_OFF_TXBUF: begin
                    s_nxt.txHold = pwdata[7:0];
                    s_nxt.txFull = 1'b1;                                   // see [RQ10]
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.brt    <= UH_BRT_RST;
            s_r.txd    <= 1'b1;
            s_r.rxMeta <= 1'b1;
            s_r.rxSync <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata   = s_r.rdData;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign txdPin   = s_r.txd ^ s_r.neg;                                   // see [RQ4]
    assign txIrqReq = s_r.txIrqPulse;
    assign rxIrqReq = s_r.rxIrqPulse;
    assign txDmaReq = !s_r.txFull;                                         // see [RQ21]
    assign rxDmaReq = s_r.rxUnread;                                        // see [RQ20]

endmodule

/* File: rtl/uh_pkg.sv */
// Shared constants and types for the half-buffered serial port
package uh_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the APB bus)
    // ------------------------------------------------------------
    localparam int          UH_ADDR_W      = 12;
    localparam logic [11:0] UH_OFF_CTRL    = 12'h000;  // uart_control_reg
    localparam logic [11:0] UH_OFF_RXBUF   = 12'h004;  // rx_holding_buffer
    localparam logic [11:0] UH_OFF_MODE    = 12'h008;  // frame_mode_reg
    localparam logic [11:0] UH_OFF_BRT     = 12'h00c;  // bit_period_count
    localparam logic [11:0] UH_OFF_RXSTAT  = 12'h010;  // rx_error_status
    localparam logic [11:0] UH_OFF_TXBUF   = 12'h014;  // tx_holding_buffer
    localparam logic [11:0] UH_OFF_TXSTAT  = 12'h030;  // transmit status
    localparam logic [11:0] UH_OFF_INTF    = 12'h038;  // uart_interrupt_source_flags

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UH_CTRL_RUN     = 0;   // uart_run_enable
    localparam int UH_CTRL_TXRUN   = 1;   // tx_run_enable
    localparam int UH_MODE_CK_LSB  = 1;   // generator_clock_select, 2 bits
    localparam int UH_MODE_RSS     = 6;   // sample_shift_select
    localparam int UH_MODE_LEN_LSB = 8;   // data length code, 2 bits
    localparam int UH_MODE_PAR_LSB = 10;  // parity code, 2 bits
    localparam int UH_MODE_STP     = 12;  // two stop bits
    localparam int UH_MODE_NEG     = 13;  // negative logic
    localparam int UH_MODE_DIR     = 14;  // MSB first
    localparam int UH_STAT_FER     = 0;   // framing_error_flag
    localparam int UH_STAT_OER     = 1;   // overrun_error_flag
    localparam int UH_STAT_PER     = 2;   // parity_error_flag
    localparam int UH_TXSTAT_FULL  = 3;   // tx_buffer_full
    localparam int UH_INT_RX       = 0;   // rx_irq_flag
    localparam int UH_INT_TX       = 1;   // tx_irq_flag

    // ------------------------------------------------------------
    // Widths, codes and reset values
    // ------------------------------------------------------------
    localparam int          UH_BRT_W      = 14;
    localparam logic [13:0] UH_BRT_RST    = 14'h3fff;
    localparam logic [1:0]  UH_CK_LOW     = 2'h0;
    localparam logic [1:0]  UH_CK_HIGH    = 2'h2;
    localparam logic [2:0]  UH_LAST_BIT8  = 3'h7;
    localparam logic [7:0]  UH_DATA_MASK8 = 8'hff;

    // Transmit and receive sequencers, Gray coded along the frame
    typedef enum logic [2:0] {
        UH_TX_IDLE  = 3'h0,
        UH_TX_START = 3'h1,
        UH_TX_DATA  = 3'h3,
        UH_TX_PAR   = 3'h2,
        UH_TX_STOP  = 3'h6
    } uh_tx_state_t;

    typedef enum logic [2:0] {
        UH_RX_IDLE  = 3'h0,
        UH_RX_START = 3'h1,
        UH_RX_DATA  = 3'h3,
        UH_RX_PAR   = 3'h2,
        UH_RX_STOP  = 3'h6
    } uh_rx_state_t;

endpackage

/* File: rtl/uh_bit_timer.sv */
// Bit period counter clocked by generator ticks
`timescale 1ns/100ps
module uh_bit_timer
    import uh_pkg::*;
#(
    parameter int W = UH_BRT_W
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] top,
    // Status
    output logic      [W-1:0] count,
    output logic              wrap
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } uh_timer_state_t;

    uh_timer_state_t s_r;
    uh_timer_state_t s_nxt;

    // A period is top plus one ticks; idle holds the count at zero
    assign wrap  = run && tick && (s_r.cnt == top);
    assign count = s_r.cnt;

    // Next count
    always_comb begin
        s_nxt = s_r;
        if (!run || wrap) begin
            s_nxt.cnt = '0;
        end else if (tick) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

/* File: testbench/uh_uart_properties.sv */
// Concurrent checks on the bus and request ports of the serial port
`timescale 1ns/100ps
module uh_uart_properties
    import uh_pkg::*;
(
    // Clock, reset and bus
    input wire logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    // Requests
    input wire logic        txIrqReq, rxIrqReq, txDmaReq, rxDmaReq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Interrupt requests are single pulses; a stuck one would flood software
    a_txirq_pulse: assert property (txIrqReq |=> !txIrqReq)
        else $error("tx request too long");
    a_rxirq_pulse: assert property (rxIrqReq |=> !rxIrqReq)
        else $error("rx request too long");
    a_txfull_set: assert property (psel && penable && pwrite && paddr == UH_OFF_TXBUF |=> !txDmaReq)
        else $error("tx buffer write did not fill");
    a_txdma_irq: assert property (txIrqReq |-> txDmaReq)
        else $error("buffer still full at tx request");
    a_rxirq_dma: assert property (rxIrqReq |-> rxDmaReq)
        else $error("no rx dma request");
    a_rxread_clear: assert property (psel && penable && !pwrite && paddr == UH_OFF_RXBUF |=> !rxDmaReq)
        else $error("rx dma request after read");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("wait state inserted");
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule
bind uh_uart uh_uart_properties chk (.*);

/* File: testbench/uh_remote.sv */
// Remote serial device driving the receive line with whole frames
`timescale 1ns/100ps
module uh_remote (
    // Clock reference and line
    input  wire logic sys_clk,
    output logic      rxdPin
);
    // Line idles at mark so the receiver sees no start edge
    initial rxdPin = 1'b1;
    // Start, 8 data LSB first, even parity (flip forces an error), stop; 8 clocks a bit
    task automatic send(input logic [7:0] d, input logic flip);
        logic [10:0] fr;
        fr = {1'b1, (^d) ^ flip, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk);
            rxdPin <= fr[i];
            repeat (7) @(posedge sys_clk);
        end
    endtask
endmodule

/* File: testbench/uart_half_buffered_serial_test.sv */
// Self-checking bench for the half-buffered serial port
`timescale 1ns/100ps
module uart_half_buffered_serial_test;
    import uh_pkg::*;
    logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, a;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, wd, ex;
    logic        pready, pslverr, txdPin, rxdPin, txIrqReq, rxIrqReq, txDmaReq, rxDmaReq, e, er;
    logic [10:0] f;
    int          n_errors = 0, n_compared = 0;
    // Rows: address, write data, read-back, bus error
    logic [76:0] rows [4] = '{{UH_OFF_BRT, 32'h0000ffff, 32'h00003fff, 1'b0},
        {UH_OFF_MODE, 32'hffffffff, 32'h00007f46, 1'b0}, {UH_OFF_RXSTAT, 32'h7, 32'h0, 1'b0},
        {12'h020, 32'h5, 32'h0, 1'b1}};
    always #4 sys_clk = ~sys_clk;
    uh_uart DUT (.*, .lowSpeedTick(1'b0), .highSpeedTick(1'b1));
    uh_remote peer (.sys_clk(sys_clk), .rxdPin(rxdPin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {rd, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic wt(ref logic s, input int n);
        repeat (n) if (s !== 1'b1) @(negedge sys_clk);
    endtask
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            {a, wd, ex, er} = rows[i];
            apb(1'b1, a, wd);
            apb(1'b0, a, 32'h0);
            chk(rd, ex);
            chk(32'(e), 32'(er));
        end
        $display("register table done");
        // Fast ticks, 8 bits, even parity, 8 clocks a bit
        apb(1'b1, UH_OFF_MODE, 32'h4);
        apb(1'b1, UH_OFF_BRT, 32'h7);
        apb(1'b1, UH_OFF_CTRL, 32'h3);
        apb(1'b1, UH_OFF_TXBUF, 32'ha5);
        f = {1'b1, ^8'ha5, 8'ha5, 1'b0};
        wt(txIrqReq, 4);
        chk(32'(txIrqReq), 32'h1);
        apb(1'b1, UH_OFF_TXBUF, 32'h3c);
        repeat (2) @(negedge sys_clk);
        // Two frames back to back, the second refilled during the first start bit
        for (int i = 0; i < 22; i++) begin
            if (i == 11) f = {1'b1, ^8'h3c, 8'h3c, 1'b0};
            chk(32'(txdPin), 32'(f[i % 11]));
            chk(32'(txDmaReq), 32'(i > 10));
            repeat (i < 21 ? 8 : 0) @(negedge sys_clk);
        end
        wt(txIrqReq, 8);
        chk(32'(txIrqReq), 32'h1);
        apb(1'b0, UH_OFF_CTRL, 32'h0);
        chk(rd, 32'h1);
        $display("transmit done");
        fork
            peer.send(8'h3c, 1'b0);
            begin
                wt(rxIrqReq, 120);
                chk(32'(rxIrqReq), 32'h1);
            end
        join
        chk(32'(rxDmaReq), 32'h1);
        apb(1'b0, UH_OFF_RXBUF, 32'h0);
        chk(rd, 32'h3c);
        peer.send(8'h3c, 1'b0);
        peer.send(8'h5a, 1'b1);
        apb(1'b0, UH_OFF_RXSTAT, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, UH_OFF_INTF, 32'h2);
        apb(1'b0, UH_OFF_INTF, 32'h0);
        chk(rd, 32'h1);
        $display("receive done");
        // Negative logic turns the idle line low; the write lands at the bus edge
        apb(1'b1, UH_OFF_MODE, 32'h2004);
        @(negedge sys_clk);
        chk(32'(txdPin), 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, UH_OFF_BRT, 32'h0);
        chk(rd, 32'h3fff);
        chk(32'(rxDmaReq), 32'h0);
        chk(32'(txdPin), 32'h1);
        $display("reset done");
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
endmodule
